// ===== artf_pkg.sv
// shared constants for the asynchronous transmit framer
package artf_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_PKTS = 8'h08;
  // control register fields and reset value
  localparam int CTRL_BUS_LSB = 0;
  localparam int CTRL_PHY_LSB = 16;
  localparam int CTRL_EN_BIT = 31;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // status register fields
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  // host control and destination quadlet fields
  localparam int SEL_BIT = 18;
  localparam int SPD_LSB = 16;
  localparam int RT_LSB = 8;
  localparam int TC_LSB = 4;
  localparam int RCODE_LSB = 12;
  localparam logic [9:0] LOCAL_BUS = 10'h3ff;
  // transaction codes handled here
  localparam logic [3:0] TC_WR_QUAD = 4'h0;
  localparam logic [3:0] TC_WR_BLK = 4'h1;
  localparam logic [3:0] TC_WR_RESP = 4'h2;
  localparam logic [3:0] TC_RD_QUAD = 4'h4;
  localparam logic [3:0] TC_RD_BLK = 4'h5;
  localparam logic [3:0] TC_RD_QRESP = 4'h6;
  localparam logic [3:0] TC_LOCK = 4'h9;
  // quadlets that follow the destination quadlet, per layout
  localparam logic [14:0] BODY_WQ = 15'h0002;
  localparam logic [14:0] BODY_RQ = 15'h0001;
  localparam logic [14:0] BODY_WR = 15'h0001;
  localparam logic [14:0] BODY_RR = 15'h0002;
  localparam logic [14:0] BODY_BLK = 15'h0002;
  typedef enum logic [1:0] {ST_CTRL, ST_DEST, ST_BODY} artf_state_t;
endpackage

// ===== artf_byte_ser.sv
// quadlet to byte serializer, most significant byte first
`timescale 1ns/1ps
`default_nettype none
module artf_byte_ser (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [31:0] q_data,
  input wire logic q_valid,
  input wire logic q_last,
  output logic q_idle,
  output logic [7:0] byte_out,
  output logic byte_valid,
  output logic byte_last,
  input wire logic byte_ready
);
  logic [23:0] sh_r;
  logic [1:0] cnt_r;
  logic last_r;

  // load on idle, step one byte per accepted beat
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sh_r <= 24'h00_0000;
      cnt_r <= 2'h0;
      last_r <= 1'b0;
      q_idle <= 1'b1;
      byte_out <= 8'h00;
      byte_valid <= 1'b0;
      byte_last <= 1'b0;
    end else if (q_idle && q_valid) begin
      byte_out <= q_data[31:24];
      sh_r <= q_data[23:0];
      cnt_r <= 2'h3;
      last_r <= q_last;
      q_idle <= 1'b0;
      byte_valid <= 1'b1;
      byte_last <= 1'b0;
    end else if (byte_valid && byte_ready) begin
      if (cnt_r != 2'h0) begin
        byte_out <= sh_r[23:16];
        sh_r <= {sh_r[15:0], 8'h00};
        cnt_r <= cnt_r - 2'h1;
        byte_last <= last_r && (cnt_r == 2'h1);
      end else begin
        byte_valid <= 1'b0;
        byte_last <= 1'b0;
        q_idle <= 1'b1;
      end
    end
  end

  a_msb_first: assert property (@(posedge clk_sys) disable iff (!rst_b)
    q_idle && q_valid |=> byte_valid && byte_out == $past(q_data[31:24]))
    else $error("serializer did not start with the top byte");
endmodule
`default_nettype wire

// ===== artf_tx_framer.sv
// asynchronous request and quadlet response transmit framer
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - source bus from node register when select bit is 0, else 0x3FF.
// - destination ID is 10-bit bus ID above 6-bit physical ID.
// - requests carry a 48-bit offset, upper part beside source ID.
// - the response code from the host is sent in every response.
// - each packet carries the retry field given by the host.
// - tx_speed loads the host's speed at each destination quadlet, even while the prior packet's tail still goes out.
// - transaction code sets the packet type and the header layout.
module artf_tx_framer (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] hq_data,
  input wire logic hq_valid,
  output logic hq_ready,
  output logic [7:0] tx_byte,
  output logic tx_byte_valid,
  output logic tx_byte_last,
  input wire logic phy_ready,
  output logic [1:0] tx_speed
);
  import artf_pkg::*;

  artf_state_t st_r, st_nxt;
  logic [31:0] ctrl_r, ctrl_q_r, pend_r, pend_nxt, hold_r, hold_nxt;
  logic pend_v_r, pend_v_nxt, pend_last_r, pend_last_nxt, hold_v_r, hold_v_nxt;
  logic [14:0] body_left_r, body_left_nxt, len_quads;
  logic blk_r, resp_r, len_seen_r, err_r, err_set, ser_idle, take, acc;
  logic [31:0] pkt_cnt_r;
  logic pkt_done;
  logic [15:0] src_id;
  logic [15:0] dec;

  // layout from transaction code: {valid, block, response, body count}
  function automatic logic [17:0] decode(input logic [3:0] tc);
    case (tc)
      TC_WR_QUAD: decode = {3'b100, BODY_WQ};
      TC_RD_QUAD: decode = {3'b100, BODY_RQ};
      TC_WR_RESP: decode = {3'b101, BODY_WR};
      TC_RD_QRESP: decode = {3'b101, BODY_RR};
      TC_WR_BLK, TC_RD_BLK, TC_LOCK: decode = {3'b110, BODY_BLK};
      default: decode = 18'h0_0000;
    endcase
  endfunction

  logic [17:0] dec_hq, dec_q;
  assign dec_hq = decode(hq_data[TC_LSB +: 4]);
  assign dec_q = decode(ctrl_q_r[TC_LSB +: 4]);
  assign dec = dec_q[15:0];
  assign acc = hq_valid && hq_ready;
  assign take = pend_v_r && ser_idle;
  // rounds byte length up to whole quadlets; padding is already in the data
  assign len_quads = 15'((17'(hq_data[31:16]) + 17'h0_0003) >> 2);
  // source bus chosen by the select bit of the control quadlet
  assign src_id = {ctrl_q_r[SEL_BIT] ? LOCAL_BUS : ctrl_r[CTRL_BUS_LSB +: 10],
                   ctrl_r[CTRL_PHY_LSB +: 6]};

  // next datapath contents: one quadlet in flight plus one held behind it
  always_comb begin
    st_nxt = st_r;
    pend_nxt = pend_r;
    pend_v_nxt = pend_v_r;
    pend_last_nxt = pend_last_r;
    hold_nxt = hold_r;
    hold_v_nxt = hold_v_r;
    body_left_nxt = body_left_r;
    err_set = 1'b0;
    pkt_done = 1'b0;
    if (take) begin
      pend_nxt = hold_r;
      pend_v_nxt = hold_v_r;
      pend_last_nxt = 1'b0;
      hold_v_nxt = 1'b0;
    end
    if (acc) begin
      case (st_r)
        ST_CTRL: begin
          if (dec_hq[17]) begin
            st_nxt = ST_DEST;
          end else begin
            err_set = 1'b1;
          end
        end
        ST_DEST: begin
          // first wire quadlet: destination ID, then label, retry, code, priority
          pend_nxt = {hq_data[31:16], ctrl_q_r[15:0]};
          pend_v_nxt = 1'b1;
          pend_last_nxt = 1'b0;
          // second: source ID, then upper offset or response code
          hold_nxt = {src_id, hq_data[15:0]};
          hold_v_nxt = 1'b1;
          body_left_nxt = dec[14:0];
          st_nxt = ST_BODY;
        end
        ST_BODY: begin
          pend_nxt = hq_data;
          pend_v_nxt = 1'b1;
          if (blk_r && !len_seen_r && body_left_r == 15'h0001) begin
            body_left_nxt = len_quads;
          end else begin
            body_left_nxt = body_left_r - 15'h0001;
          end
          pend_last_nxt = (body_left_nxt == 15'h0000);
          if (pend_last_nxt) begin
            st_nxt = ST_CTRL;
            pkt_done = 1'b1;
          end
        end
        default: st_nxt = ST_CTRL;
      endcase
    end
  end

  // framing state and datapath registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_r <= ST_CTRL;
      pend_r <= 32'h0000_0000;
      pend_v_r <= 1'b0;
      pend_last_r <= 1'b0;
      hold_r <= 32'h0000_0000;
      hold_v_r <= 1'b0;
      body_left_r <= 15'h0000;
      hq_ready <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pend_r <= pend_nxt;
      pend_v_r <= pend_v_nxt;
      pend_last_r <= pend_last_nxt;
      hold_r <= hold_nxt;
      hold_v_r <= hold_v_nxt;
      body_left_r <= body_left_nxt;
      // stall the host while anything waits for the serializer
      hq_ready <= ctrl_r[CTRL_EN_BIT] && !pend_v_nxt && !hold_v_nxt;
    end
  end

  // per-packet fields caught from the control quadlet
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_q_r <= 32'h0000_0000;
      blk_r <= 1'b0;
      resp_r <= 1'b0;
      len_seen_r <= 1'b0;
      tx_speed <= 2'h0;
    end else if (acc) begin
      if (st_r == ST_CTRL) begin
        ctrl_q_r <= hq_data;
        blk_r <= dec_hq[16];
        resp_r <= dec_hq[15];
      end
      if (st_r == ST_DEST) begin
        tx_speed <= ctrl_q_r[SPD_LSB +: 2];
        len_seen_r <= 1'b0;
      end
      if (st_r == ST_BODY && blk_r && body_left_r == 15'h0001) begin
        len_seen_r <= 1'b1;
      end
    end
  end

  // register writes, error flag and packet counter
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
      err_r <= 1'b0;
      pkt_cnt_r <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == REG_CTRL) begin
        ctrl_r <= reg_wdata;
      end
      // a new error beats a clear in the same cycle
      if (err_set) begin
        err_r <= 1'b1;
      end else if (reg_wr && reg_addr == REG_STAT && reg_wdata[STAT_ERR_BIT]) begin
        err_r <= 1'b0;
      end
      if (pkt_done) begin
        pkt_cnt_r <= pkt_cnt_r + 32'h0000_0001;
      end
    end
  end

  // read data stand for one cycle only; unmapped reads give zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= ctrl_r;
        REG_STAT: reg_rdata <= {30'h0000_0000,
                                (st_r != ST_CTRL) || pend_v_r || hold_v_r, err_r};
        REG_PKTS: reg_rdata <= pkt_cnt_r;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  artf_byte_ser u_ser (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .q_data(pend_r),
    .q_valid(pend_v_r),
    .q_last(pend_last_r),
    .q_idle(ser_idle),
    .byte_out(tx_byte),
    .byte_valid(tx_byte_valid),
    .byte_last(tx_byte_last),
    .byte_ready(phy_ready)
  );

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_src_local_bus: assert property (
    acc && st_r == ST_DEST && ctrl_q_r[SEL_BIT] |=> hold_r[31:22] == LOCAL_BUS)
    else $error("local bus value missing from source ID");
  a_src_node_bus: assert property (
    acc && st_r == ST_DEST && !ctrl_q_r[SEL_BIT]
    |=> hold_r[31:22] == $past(ctrl_r[CTRL_BUS_LSB +: 10]))
    else $error("node bus ID missing from source ID");
  a_dest_id_split: assert property (
    acc && st_r == ST_DEST |=> pend_r[31:22] == $past(hq_data[31:22])
    && pend_r[21:16] == $past(hq_data[21:16]) && hold_v_r)
    else $error("destination bus or physical ID misplaced");
  a_offset_upper: assert property (
    acc && st_r == ST_DEST && !resp_r |=> hold_r[15:0] == $past(hq_data[15:0]))
    else $error("upper offset not beside source ID");
  a_rcode_sent: assert property (
    acc && st_r == ST_DEST && resp_r
    |=> hold_r[RCODE_LSB +: 4] == $past(hq_data[RCODE_LSB +: 4]))
    else $error("response code altered");
  a_retry_kept: assert property (
    acc && st_r == ST_DEST |=> pend_r[RT_LSB +: 2] == ctrl_q_r[RT_LSB +: 2])
    else $error("retry field altered");
  a_speed_held: assert property (
    st_r == ST_BODY |-> tx_speed == ctrl_q_r[SPD_LSB +: 2])
    else $error("speed differs from the selected one");
  a_quad_read_body: assert property (
    acc && st_r == ST_DEST && ctrl_q_r[TC_LSB +: 4] == TC_RD_QUAD
    |=> body_left_r == 15'h0001)
    else $error("quadlet read request body count wrong");
  // a quadlet read ends with its single body quadlet
  a_quad_read_len: assert property (
    acc && st_r == ST_BODY && ctrl_q_r[TC_LSB +: 4] == TC_RD_QUAD
    |=> st_r == ST_CTRL && pend_last_r)
    else $error("quadlet read request length wrong");
  a_header_order: assert property (
    take && hold_v_r |=> pend_v_r && pend_r == $past(hold_r) && !hold_v_r)
    else $error("second header quadlet out of order");
endmodule
`default_nettype wire

// ===== artf_host_model.sv
// host side model: feeds transmit quadlets with a valid/ready handshake
`timescale 1ns/1ps
`default_nettype none
module artf_host_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic stall,
  input wire logic hq_ready,
  output logic [31:0] hq_data,
  output logic hq_valid
);
  logic [31:0] fifo[$];

  // quadlets of one packet are queued by the bench in header order
  task automatic put(input logic [31:0] q);
    fifo.push_back(q);
  endtask

  // head quadlet held until taken; idle data toggles so no stale value passes
  always @(posedge clk_sys) begin
    if (hq_valid && hq_ready) begin
      void'(fifo.pop_front());
    end
    if (!rst_b) begin
      hq_valid <= 1'b0;
      hq_data <= 32'h0000_0000;
    end else if (hq_valid && !hq_ready) begin
      hq_valid <= 1'b1;
    end else if (fifo.size() > 0 && !stall) begin
      hq_valid <= 1'b1;
      hq_data <= fifo[0];
    end else begin
      hq_valid <= 1'b0;
      hq_data <= ~hq_data;
    end
  end
endmodule
`default_nettype wire

// ===== artf_tx_framer_tb_top.sv
// self-checking bench for the asynchronous transmit framer
`timescale 1ns/1ps
`default_nettype none
module artf_tx_framer_tb_top;
  import artf_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic phy_ready = 1'b0;
  logic stall = 1'b0;
  logic [31:0] reg_rdata, hq_data, seed = 32'h56ca_c11b;
  logic hq_valid, hq_ready, tx_byte_valid, tx_byte_last;
  logic [7:0] tx_byte;
  logic [1:0] tx_speed, exp_spd = 2'b00;
  logic [9:0] node_bus = 10'h2a5;
  logic [5:0] node_phy = 6'h13;
  logic [5:0] lbl = 6'h00;
  logic [8:0] got[$], exp_q[$];
  logic [3:0] tcs[7] = '{TC_WR_QUAD, TC_WR_BLK, TC_WR_RESP, TC_RD_QUAD, TC_RD_BLK,
    TC_RD_QRESP, TC_LOCK};
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #25 clk_sys = ~clk_sys;

  artf_tx_framer dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hq_data(hq_data), .hq_valid(hq_valid), .hq_ready(hq_ready), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid), .tx_byte_last(tx_byte_last), .phy_ready(phy_ready),
    .tx_speed(tx_speed));
  artf_host_model host (.clk_sys(clk_sys), .rst_b(rst_b), .stall(stall),
    .hq_ready(hq_ready), .hq_data(hq_data), .hq_valid(hq_valid));

  function automatic logic [31:0] nxt();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (!ok) begin
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic results();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // random stalls at both ends, byte capture and the hang limit
  always @(posedge clk_sys) begin
    if (tx_byte_valid && phy_ready) got.push_back({tx_byte_last, tx_byte});
    if (tx_byte_valid && tx_byte_last && phy_ready) check(tx_speed === exp_spd, "speed");
    phy_ready <= nxt() != 32'h0000_0000 && (seed[3] | seed[7]);
    stall <= seed[5] & seed[9];
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata === e, m);
  endtask

  // one packet: host quadlets in, expected wire bytes worked out here
  task automatic send(input logic [3:0] tc, input logic [15:0] len);
    logic [31:0] c, d, w, q[$];
    w = nxt();
    c = {13'h0000, w[18:16], lbl, w[9:8], tc, 4'h0};
    d = nxt();
    if (tc != TC_WR_RESP && tc != TC_RD_QRESP) q.push_back(nxt() & 32'hffff_fffc);
    else q.push_back(32'h0000_0000);
    if (tc inside {TC_WR_BLK, TC_RD_BLK, TC_LOCK}) begin
      w = nxt();
      q.push_back({len, (tc == TC_LOCK) ? w[15:0] : 16'h0000});
      for (int k = 0; k < (len + 3) / 4; k++) q.push_back(nxt());
      if (len[1:0] != 2'b00) q[$] = q[$] & ~(32'hffff_ffff >> (8 * len[1:0]));
    end else if (tc inside {TC_WR_QUAD, TC_RD_QRESP}) q.push_back(nxt());
    exp_spd = c[17:16];
    host.put(c);
    host.put(d);
    foreach (q[k]) host.put(q[k]);
    q.push_front({c[18] ? LOCAL_BUS : node_bus, node_phy, d[15:0]});
    q.push_front({d[31:16], c[15:0]});
    foreach (q[k]) for (int j = 3; j >= 0; j--)
      exp_q.push_back({k == q.size() - 1 && j == 0, q[k][8*j +: 8]});
    for (int k = 0; k < 600 && got.size() < exp_q.size(); k++) begin
      @(posedge clk_sys);
      #1;
    end
    check(got.size() == exp_q.size(), "byte count");
    foreach (exp_q[k]) if (k < got.size()) check(got[k] === exp_q[k], "byte");
    got.delete();
    exp_q.delete();
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    reg_read(REG_CTRL, CTRL_RST, "ctrl reset");
    reg_read(REG_PKTS, 32'h0000_0000, "count reset");
    reg_write(REG_CTRL, {1'b1, 9'h000, node_phy, 6'h00, node_bus});
    reg_read(REG_CTRL, {1'b1, 9'h000, node_phy, 6'h00, node_bus}, "ctrl rw");
    reg_read(8'h3c, 32'h0000_0000, "unmapped");
    for (int i = 0; i < 28; i++) begin
      // responses reuse the label of the last request
      if (!(tcs[i % 7] inside {TC_WR_RESP, TC_RD_QRESP})) lbl = 6'(nxt() >> 28);
      send(tcs[i % 7], (i < 7) ? 16'h0004 : {12'h000, seed[3:0]} + 16'h0001);
    end
    // unknown transaction code is dropped and flagged
    host.put({24'h00_0000, 4'h3, 4'h0});
    send(TC_RD_QUAD, 16'h0004);
    repeat (4) @(posedge clk_sys);
    reg_read(REG_STAT, 32'h0000_0001, "error flag");
    reg_write(REG_STAT, 32'h0000_0001);
    reg_read(REG_STAT, 32'h0000_0000, "error clear");
    reg_read(REG_PKTS, 32'h0000_001d, "packet count");
    results();
  end
endmodule
`default_nettype wire
